// ---- swcr_bank.sv ----
/*
 selective-wake configuration register bank with calibration control,
 bus-timeout interrupt gating and the configuration-valid handshake.
 the timeout flag and the operating mode are ports, not mapped registers;
 the option register sits at a spare address outside the bank.
 assumes a serial-interface decoder that delivers one-cycle read/write
 strobes with a 7-bit address, synchronous to mclk; power-on/soft reset
 arrives on reset, restart on restart.
 every output leaves from a register, so status lags internal state by
 one cycle.
*/
`timescale 1ns/1ps
`include "swcr_consts.svh"
module swcr_bank (
   input wire logic mclk,
   input wire logic reset,
   input wire logic restart,
   input wire swcr_pkg::swcr_req_s req,
   input wire swcr_pkg::swcr_mode_e mode,
   input wire logic wake_up_event,
   input wire logic bus_timeout_event,
   input wire logic bus_timeout_clear,
   input wire logic bus_transmit_input,
   output logic [7:0] rdata,
   output logic rvalid,
   output logic interrupt_out_n,
   output logic selective_wake_enable,
   output logic bus_timeout_flag,
   output logic oscillator_calibration_active,
   output logic trim_reference,
   output logic [7:0] wake_option_register,
   output swcr_pkg::swcr_wake_cfg_s wake_cfg
);
   import swcr_pkg::*;

   // ----------------------------------------
   // address decode
   // ----------------------------------------
   function automatic logic hit(input logic [6:0] a, input logic [6:0] r);
      hit = (a == r);
   endfunction

   // each address is matched once; the read and write strobes share the match
   wire sel_ctrl = hit(req.addr, `SWCR_ADDR_CTRL);
   wire sel_quanta = hit(req.addr, `SWCR_ADDR_QUANTA);
   wire sel_sample = hit(req.addr, `SWCR_ADDR_SAMPLE);
   wire sel_id_top = hit(req.addr, `SWCR_ADDR_ID_TOP);
   wire sel_id_umid = hit(req.addr, `SWCR_ADDR_ID_UMID);
   wire sel_id_lmid = hit(req.addr, `SWCR_ADDR_ID_LMID);
   wire sel_id_bot = hit(req.addr, `SWCR_ADDR_ID_BOT);
   wire sel_option = hit(req.addr, `SWCR_ADDR_OPTION);

   wire wr_ctrl = req.wr && sel_ctrl;
   wire wr_quanta = req.wr && sel_quanta;
   wire wr_sample = req.wr && sel_sample;
   wire wr_id_top = req.wr && sel_id_top;
   wire wr_id_umid = req.wr && sel_id_umid;
   wire wr_id_lmid = req.wr && sel_id_lmid;
   wire wr_id_bot = req.wr && sel_id_bot;
   wire wr_option = req.wr && sel_option;

   // ----------------------------------------
   // control register
   // ----------------------------------------
   logic [7:0] ctrl_ff;
   logic [7:0] nxt_ctrl;
   logic cfg_changed;
   logic unlocked;
   logic valid_clear;

   // any write to timing or identifier data counts as a change
   assign cfg_changed = wr_quanta | wr_sample | wr_id_top | wr_id_umid |
                        wr_id_lmid | wr_id_bot;
   // the key comes from the stored control byte, never from a write in flight
   assign unlocked = (ctrl_ff[`SWCR_CTRL_KEY_HI:`SWCR_CTRL_KEY_LO]
                      == `SWCR_KEY_UNLOCK);
   // hardware clear wins here: a stale valid after a change would be unsafe
   assign valid_clear = wake_up_event | cfg_changed;

   // restart keeps calibration and masking but drops valid: wake must be re-armed
   always_comb begin
      nxt_ctrl = ctrl_ff;
      if (restart) begin
         nxt_ctrl = {ctrl_ff[7:4], 4'h0};
      end else begin
         if (wr_ctrl) begin
            nxt_ctrl = req.wdata & `SWCR_CTRL_WMASK;
         end
         if (valid_clear) begin
            nxt_ctrl[`SWCR_CTRL_VALID_BIT] = 1'b0;
         end
      end
   end

   always_ff @(posedge mclk) begin
      if (reset) begin
         ctrl_ff <= `SWCR_RST_CTRL;
      end else begin
         ctrl_ff <= nxt_ctrl;
      end
   end

   // ----------------------------------------
   // timing, identifier and option registers
   // ----------------------------------------
   logic [7:0] quanta_q;
   logic [7:0] sample_q;
   logic [7:0] id_top_q;
   logic [7:0] id_umid_q;
   logic [7:0] id_lmid_q;
   logic [7:0] id_bot_q;
   logic [7:0] option_q;

   // identifier and timing bytes survive restart; only reset reloads them
   swcr_reg8 #(.RST_VAL(`SWCR_RST_QUANTA), .WMASK(8'hff), .KEEP_ON_RESTART(8'hff))
   u_quanta (
      .mclk(mclk),
      .reset(reset),
      .restart(restart),
      .wr_en(wr_quanta),
      .wdata(req.wdata),
      .q(quanta_q));

   swcr_reg8 #(.RST_VAL(`SWCR_RST_SAMPLE), .WMASK(`SWCR_SAMPLE_WMASK),
      .KEEP_ON_RESTART(8'hff))
   u_sample (
      .mclk(mclk),
      .reset(reset),
      .restart(restart),
      .wr_en(wr_sample),
      .wdata(req.wdata),
      .q(sample_q));

   swcr_reg8 #(.RST_VAL(`SWCR_RST_ID), .WMASK(8'hff), .KEEP_ON_RESTART(8'hff))
   u_id_top (
      .mclk(mclk),
      .reset(reset),
      .restart(restart),
      .wr_en(wr_id_top),
      .wdata(req.wdata),
      .q(id_top_q));

   swcr_reg8 #(.RST_VAL(`SWCR_RST_ID), .WMASK(8'hff), .KEEP_ON_RESTART(8'hff))
   u_id_umid (
      .mclk(mclk),
      .reset(reset),
      .restart(restart),
      .wr_en(wr_id_umid),
      .wdata(req.wdata),
      .q(id_umid_q));

   swcr_reg8 #(.RST_VAL(`SWCR_RST_ID), .WMASK(8'hff), .KEEP_ON_RESTART(8'hff))
   u_id_lmid (
      .mclk(mclk),
      .reset(reset),
      .restart(restart),
      .wr_en(wr_id_lmid),
      .wdata(req.wdata),
      .q(id_lmid_q));

   swcr_reg8 #(.RST_VAL(`SWCR_RST_ID), .WMASK(`SWCR_ID_BOT_WMASK),
      .KEEP_ON_RESTART(8'hff))
   u_id_bot (
      .mclk(mclk),
      .reset(reset),
      .restart(restart),
      .wr_en(wr_id_bot),
      .wdata(req.wdata),
      .q(id_bot_q));

   // option register only takes writes while the key is unlocked
   swcr_reg8 #(.RST_VAL(`SWCR_RST_OPTION), .WMASK(8'hff), .KEEP_ON_RESTART(8'hff))
   u_option (
      .mclk(mclk),
      .reset(reset),
      .restart(restart),
      .wr_en(wr_option && unlocked),
      .wdata(req.wdata),
      .q(option_q));

   // ----------------------------------------
   // calibration
   // ----------------------------------------
   logic cal_active;
   logic trim_ref;

   // a locked request waits in its own state and starts once the key arrives
   swcr_cal_ctrl u_cal (
      .mclk(mclk),
      .reset(reset),
      .cal_enable(ctrl_ff[`SWCR_CTRL_CAL_BIT]),
      .unlocked(unlocked),
      .bus_transmit_input(bus_transmit_input),
      .cal_active(cal_active),
      .trim_ref(trim_ref));

   // ----------------------------------------
   // selective wake, timeout flag and interrupt
   // ----------------------------------------
   logic swk_on;
   logic run_mode;
   logic to_flag_ff;
   logic nxt_to_flag;

   assign swk_on = ctrl_ff[`SWCR_CTRL_VALID_BIT];
   // mode gates only the pin; the flag itself does not look at the mode
   assign run_mode = (mode == SWCR_MODE_NORMAL) || (mode == SWCR_MODE_STOP);
   // a timeout in the clear cycle still sets the flag
   assign nxt_to_flag = (swk_on && bus_timeout_event) ? 1'b1 :
                        bus_timeout_clear ? 1'b0 : to_flag_ff;

   always_ff @(posedge mclk) begin
      if (reset) begin
         to_flag_ff <= 1'b0;
      end else begin
         to_flag_ff <= nxt_to_flag;
      end
   end

   // ----------------------------------------
   // read path and registered outputs
   // ----------------------------------------
   logic [7:0] rd_mux;

   // unmapped addresses select nothing and read as zero
   assign rd_mux = ({8{sel_ctrl}} & ctrl_ff & `SWCR_CTRL_WMASK) |
                   ({8{sel_quanta}} & quanta_q) |
                   ({8{sel_sample}} & sample_q) |
                   ({8{sel_id_top}} & id_top_q) |
                   ({8{sel_id_umid}} & id_umid_q) |
                   ({8{sel_id_lmid}} & id_lmid_q) |
                   ({8{sel_id_bot}} & id_bot_q) |
                   ({8{sel_option}} & option_q);

   logic [7:0] rdata_ff;
   logic rvalid_ff;
   logic irq_n_ff;
   logic swk_en_ff;
   logic to_out_ff;
   logic cal_out_ff;
   logic trim_out_ff;
   logic [7:0] option_out_ff;
   swcr_wake_cfg_s cfg_ff;

   always_ff @(posedge mclk) begin
      if (reset) begin
         rdata_ff <= 8'h00;
         rvalid_ff <= 1'b0;
         irq_n_ff <= 1'b1;
         swk_en_ff <= 1'b0;
         to_out_ff <= 1'b0;
         cal_out_ff <= 1'b0;
         trim_out_ff <= 1'b0;
         option_out_ff <= `SWCR_RST_OPTION;
         cfg_ff <= '0;
      end else begin
         // zero outside a read, so the valid strobe alone qualifies the data
         rdata_ff <= req.rd ? rd_mux : 8'h00;
         rvalid_ff <= req.rd;
         irq_n_ff <= ~(to_flag_ff & ctrl_ff[`SWCR_CTRL_TO_IRQ_BIT] & swk_on & run_mode);
         swk_en_ff <= swk_on;
         to_out_ff <= to_flag_ff;
         cal_out_ff <= cal_active;
         trim_out_ff <= trim_ref;
         option_out_ff <= option_q;
         // standard ids live in the top 11 positions
         cfg_ff.ident <= {id_top_q, id_umid_q, id_lmid_q, id_bot_q[6:2]};
         cfg_ff.remote_req <= id_bot_q[`SWCR_ID_BOT_RTR_BIT];
         cfg_ff.extended <= id_bot_q[`SWCR_ID_BOT_IDE_BIT];
         cfg_ff.quanta_per_bit <= quanta_q;
         cfg_ff.sample_point_fraction <= sample_q[5:0];
      end
   end

   assign rdata = rdata_ff;
   assign rvalid = rvalid_ff;
   assign interrupt_out_n = irq_n_ff;
   assign selective_wake_enable = swk_en_ff;
   assign bus_timeout_flag = to_out_ff;
   assign oscillator_calibration_active = cal_out_ff;
   assign trim_reference = trim_out_ff;
   assign wake_option_register = option_out_ff;
   assign wake_cfg = cfg_ff;
endmodule

// ---- swcr_bank_properties.sv ----
/*
 concurrent checks on the ports of the selective-wake configuration bank.
 assumes the bind below attaches it to every swcr_bank instance.
*/
`timescale 1ns/1ps
`include "swcr_consts.svh"
module swcr_bank_props
   import swcr_pkg::*;
(
   input wire logic mclk,
   input wire logic reset,
   input wire swcr_pkg::swcr_req_s req,
   input wire swcr_pkg::swcr_mode_e mode,
   input wire logic wake_up_event,
   input wire logic bus_timeout_event,
   input wire logic bus_transmit_input,
   input wire logic [7:0] rdata,
   input wire logic rvalid,
   input wire logic interrupt_out_n,
   input wire logic selective_wake_enable,
   input wire logic bus_timeout_flag,
   input wire logic oscillator_calibration_active,
   input wire logic trim_reference,
   input wire swcr_pkg::swcr_wake_cfg_s wake_cfg
);
   default clocking cb @(posedge mclk);
   endclocking
   default disable iff (reset);
   wire ctrl_wr = req.wr && req.addr == `SWCR_ADDR_CTRL;
   wire data_wr = req.wr && req.addr > `SWCR_ADDR_CTRL && req.addr <= `SWCR_ADDR_ID_BOT;
   // quiet cycles demanded: a later control write may legally undo the setting
   cal_on_a: assert property (ctrl_wr && req.wdata[7:5] == 3'b111
      ##1 !ctrl_wr [*4] |-> oscillator_calibration_active) else $error("calibration idle");
   cal_lock_a: assert property (ctrl_wr && req.wdata[7:5] != 3'b111
      ##1 !ctrl_wr [*4] |-> !oscillator_calibration_active) else $error("calibration ran");
   // the pin passes two register stages before it reaches the output
   trim_follow_a: assert property (oscillator_calibration_active
      && $past(oscillator_calibration_active) |-> trim_reference == $past(bus_transmit_input, 2))
      else $error("trim reference lost the pin");
   trim_idle_a: assert property (!oscillator_calibration_active
      && !$past(oscillator_calibration_active) |-> !trim_reference)
      else $error("trim reference moved while idle");
   irq_cause_a: assert property ($fell(interrupt_out_n) |-> bus_timeout_flag
      && $past(mode) inside {SWCR_MODE_NORMAL, SWCR_MODE_STOP}) else $error("stray interrupt");
   flag_gate_a: assert property ($rose(bus_timeout_flag) |-> $past(bus_timeout_event, 2)
      && $past(selective_wake_enable)) else $error("flag set with wake off");
   wake_clear_a: assert property (wake_up_event |-> ##2 !selective_wake_enable)
      else $error("valid kept after wake");
   data_clear_a: assert property (data_wr |-> ##2 !selective_wake_enable)
      else $error("valid kept after data write");
   reset_vals_a: assert property ($fell(reset) |-> ##2
      wake_cfg.quanta_per_bit == `SWCR_RST_QUANTA && wake_cfg.sample_point_fraction == 6'h33)
      else $error("timing reset values wrong");
   ctrl_rsv_a: assert property (rvalid && $past(req.addr) == `SWCR_ADDR_CTRL
      |-> rdata[3:1] == 3'b000) else $error("reserved control bits set");
endmodule
bind swcr_bank swcr_bank_props i_props (.mclk(mclk), .reset(reset), .req(req), .mode(mode),
   .wake_up_event(wake_up_event), .bus_timeout_event(bus_timeout_event),
   .bus_transmit_input(bus_transmit_input), .rdata(rdata), .rvalid(rvalid),
   .interrupt_out_n(interrupt_out_n), .selective_wake_enable(selective_wake_enable),
   .bus_timeout_flag(bus_timeout_flag),
   .oscillator_calibration_active(oscillator_calibration_active),
   .trim_reference(trim_reference), .wake_cfg(wake_cfg));

// ---- swcr_cal_ctrl.sv ----
/*
 oscillator calibration sequencer: runs while calibration is enabled and
 unlocked, and forwards the transmit pin as the trimming reference.
 assumes the transmit pin is synchronous to mclk.
*/
`timescale 1ns/1ps
module swcr_cal_ctrl
   import swcr_pkg::*;
(
   input wire logic mclk,
   input wire logic reset,
   input wire logic cal_enable,
   input wire logic unlocked,
   input wire logic bus_transmit_input,
   output logic cal_active,
   output logic trim_ref
);
   swcr_cal_e state_ff;
   swcr_cal_e nxt_state;
   logic trim_ref_ff;

   always_comb begin
      nxt_state = state_ff;
      case (state_ff)
         SWCR_CAL_IDLE: begin
            if (cal_enable && unlocked) nxt_state = SWCR_CAL_RUN;
            else if (cal_enable) nxt_state = SWCR_CAL_BLOCKED;
         end
         SWCR_CAL_RUN: begin
            if (!cal_enable || !unlocked) nxt_state = SWCR_CAL_IDLE;
         end
         SWCR_CAL_BLOCKED: begin
            if (!cal_enable) nxt_state = SWCR_CAL_IDLE;
            else if (unlocked) nxt_state = SWCR_CAL_RUN;
         end
         default: nxt_state = SWCR_CAL_IDLE;
      endcase
   end

   always_ff @(posedge mclk) begin
      if (reset) begin
         state_ff <= SWCR_CAL_IDLE;
         trim_ref_ff <= 1'b0;
      end else begin
         state_ff <= nxt_state;
         // pattern only passes while calibrating
         trim_ref_ff <= (nxt_state == SWCR_CAL_RUN) & bus_transmit_input;
      end
   end

   assign cal_active = (state_ff == SWCR_CAL_RUN);
   assign trim_ref = trim_ref_ff;
endmodule

// ---- swcr_consts.svh ----
/*
 constants of the selective-wake configuration bank: register addresses,
 field positions, reset values and the unlock key.
 assumes 7-bit register addresses as the serial register port delivers them.
*/
`ifndef SWCR_CONSTS_SVH
`define SWCR_CONSTS_SVH

// ----------------------------------------
// register addresses
// ----------------------------------------
`define SWCR_ADDR_CTRL 7'h20
`define SWCR_ADDR_QUANTA 7'h21
`define SWCR_ADDR_SAMPLE 7'h22
`define SWCR_ADDR_ID_TOP 7'h23
`define SWCR_ADDR_ID_UMID 7'h24
`define SWCR_ADDR_ID_LMID 7'h25
`define SWCR_ADDR_ID_BOT 7'h26
`define SWCR_ADDR_OPTION 7'h40

// ----------------------------------------
// field positions
// ----------------------------------------
`define SWCR_CTRL_CAL_BIT 7
`define SWCR_CTRL_KEY_HI 6
`define SWCR_CTRL_KEY_LO 5
`define SWCR_CTRL_TO_IRQ_BIT 4
`define SWCR_CTRL_VALID_BIT 0
`define SWCR_ID_BOT_RTR_BIT 1
`define SWCR_ID_BOT_IDE_BIT 0

// ----------------------------------------
// masks of writable bits, the unlock key and reset values
// ----------------------------------------
`define SWCR_CTRL_WMASK 8'hf1
`define SWCR_SAMPLE_WMASK 8'h3f
`define SWCR_ID_BOT_WMASK 8'h7f
`define SWCR_KEY_UNLOCK 2'h3
`define SWCR_RST_CTRL 8'h00
`define SWCR_RST_QUANTA 8'ha0
`define SWCR_RST_SAMPLE 8'h33
`define SWCR_RST_ID 8'h00
`define SWCR_RST_OPTION 8'h00

`endif

// ---- swcr_host.sv ----
/*
 host model: register writes and reads, and the trimming pattern on the pin.
 assumes the bank takes strobes at the rising edge of mclk.
*/
`timescale 1ns/1ps
`include "swcr_consts.svh"
module swcr_host
   import swcr_pkg::*;
(
   input wire logic mclk,
   input wire logic [7:0] rdata,
   input wire logic rvalid,
   output swcr_pkg::swcr_req_s req,
   output logic tx
);
   initial begin
      req = '0;
      tx = 1'b1;
   end
   always @(negedge mclk) tx <= 1'($urandom);
   task automatic wr(input logic [6:0] a, input logic [7:0] d);
      @(negedge mclk);
      req.wr = 1'b1;
      req.addr = a;
      // a wake frame never asks for a remote request
      req.wdata = (a == `SWCR_ADDR_ID_BOT) ? (d & 8'hfd) : d;
      @(negedge mclk);
      req = '0;
   endtask
   task automatic rd(input logic [6:0] a, output logic [7:0] d, output logic v);
      @(negedge mclk);
      req.rd = 1'b1;
      req.addr = a;
      @(negedge mclk);
      req = '0;
      d = rdata;
      v = rvalid;
   endtask
endmodule

// ---- swcr_pkg.sv ----
/*
 types of the selective-wake configuration bank.
 assumes swcr_consts.svh for the numbers.
*/
package swcr_pkg;

   typedef enum logic [1:0] {
      SWCR_MODE_NORMAL = 2'b00,
      SWCR_MODE_STOP = 2'b01,
      SWCR_MODE_SLEEP = 2'b10,
      SWCR_MODE_OTHER = 2'b11
   } swcr_mode_e;

   typedef struct packed {
      logic wr;
      logic rd;
      logic [6:0] addr;
      logic [7:0] wdata;
   } swcr_req_s;

   typedef struct packed {
      logic [28:0] ident;
      logic remote_req;
      logic extended;
      logic [7:0] quanta_per_bit;
      logic [5:0] sample_point_fraction;
   } swcr_wake_cfg_s;

   typedef enum logic [1:0] {
      SWCR_CAL_IDLE = 2'b00,
      SWCR_CAL_RUN = 2'b01,
      SWCR_CAL_BLOCKED = 2'b10
   } swcr_cal_e;

endpackage

// ---- swcr_reg8.sv ----
/*
 one 8-bit configuration register with separate power-on and restart
 behaviour and a write mask that keeps reserved bits at zero.
 assumes one clock and a synchronous reset.
*/
`timescale 1ns/1ps
module swcr_reg8 #(
   parameter logic [7:0] RST_VAL = 8'h00,
   parameter logic [7:0] WMASK = 8'hff,
   parameter logic [7:0] KEEP_ON_RESTART = 8'hff
) (
   input wire logic mclk,
   input wire logic reset,
   input wire logic restart,
   input wire logic wr_en,
   input wire logic [7:0] wdata,
   output logic [7:0] q
);
   logic [7:0] q_ff;
   logic [7:0] nxt_q;

   // restart keeps only the bits marked to survive it
   assign nxt_q = restart ? (q_ff & KEEP_ON_RESTART) :
                  wr_en ? (wdata & WMASK) : q_ff;

   always_ff @(posedge mclk) begin
      if (reset) begin
         q_ff <= RST_VAL;
      end else begin
         q_ff <= nxt_q;
      end
   end

   assign q = q_ff;
endmodule

// ---- tb_selective_wake_config_regs.sv ----
/*
 self-checking bench of the selective-wake bank against an integer model.
 assumes swcr_host drives the register strobes and the transmit pin.
*/
`timescale 1ns/1ps
`include "swcr_consts.svh"
module tb_selective_wake_config_regs;
   import swcr_pkg::*;
   logic mclk, reset, restart, wake_up_event, bus_timeout_event, bus_timeout_clear, tx;
   logic rvalid, interrupt_out_n, selective_wake_enable, bus_timeout_flag, cal_act, trim_ref;
   logic [7:0] rdata, wake_option_register, d;
   logic v;
   logic tx_d1, tx_d2;
   swcr_mode_e mode;
   swcr_req_s req;
   swcr_wake_cfg_s wake_cfg;
   int err_count = 0;
   int compares = 0;
   int opt;
   int mdl [7];
   int rst [7] = '{`SWCR_RST_CTRL, `SWCR_RST_QUANTA, `SWCR_RST_SAMPLE, 0, 0, 0, 0};
   int msk [7] = '{`SWCR_CTRL_WMASK, 8'hff, `SWCR_SAMPLE_WMASK, 8'hff, 8'hff, 8'hff,
      `SWCR_ID_BOT_WMASK};
   initial begin
      mclk = 1'b0;
      forever #50 mclk = ~mclk;
   end
   // pin history as the bank samples it, for the trimming reference check
   always @(posedge mclk) begin
      tx_d1 <= tx;
      tx_d2 <= tx_d1;
   end
   swcr_bank i_dut (.mclk(mclk), .reset(reset), .restart(restart), .req(req), .mode(mode),
      .wake_up_event(wake_up_event), .bus_timeout_event(bus_timeout_event),
      .bus_timeout_clear(bus_timeout_clear), .bus_transmit_input(tx), .rdata(rdata),
      .rvalid(rvalid), .interrupt_out_n(interrupt_out_n),
      .selective_wake_enable(selective_wake_enable), .bus_timeout_flag(bus_timeout_flag),
      .oscillator_calibration_active(cal_act), .trim_reference(trim_ref),
      .wake_option_register(wake_option_register), .wake_cfg(wake_cfg));
   swcr_host i_host (.mclk(mclk), .rdata(rdata), .rvalid(rvalid), .req(req), .tx(tx));
   task automatic chk(input logic [44:0] seen, input logic [44:0] exp);
      compares++;
      if (seen !== exp) begin
         err_count++;
         $display("BAD %0t seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic wrap_up();
      $display("compares %0d mismatches %0d", compares, err_count);
      if (err_count == 0 && compares > 0) $display("== PASSED ==");
      else $display("== FAILED ==");
      $finish;
   endtask
   task automatic pulse(ref logic s);
      s = 1'b1;
      @(negedge mclk);
      s = 1'b0;
      repeat (2) @(negedge mclk);
   endtask
   // the model mirrors masks, the unlock key and the valid-bit clearing
   task automatic wrm(input int a, input logic [7:0] dv);
      int i;
      i = a - 'h20;
      i_host.wr(a[6:0], dv);
      if (a == `SWCR_ADDR_OPTION) begin
         if (mdl[0][6:5] == 2'b11) opt = dv;
      end else if (i >= 0 && i < 7) begin
         mdl[i] = dv & msk[i] & ((i == 6) ? 8'hfd : 8'hff);
         if (i > 0) mdl[0] &= 8'hfe;
      end
   endtask
   task automatic rdall();
      for (int a = 'h20; a < 'h27; a++) begin
         i_host.rd(a[6:0], d, v);
         chk(v, 1);
         chk(d, mdl[a - 'h20][7:0]);
      end
      i_host.rd(7'h30, d, v);
      chk(d, 0);
      chk(wake_cfg, {mdl[3][7:0], mdl[4][7:0], mdl[5][7:0], mdl[6][6:0], mdl[1][7:0],
         mdl[2][5:0]});
   endtask
   task automatic do_reset();
      reset = 1'b1;
      repeat (3) @(negedge mclk);
      reset = 1'b0;
      mdl = rst;
      opt = 0;
      repeat (4) @(negedge mclk);
   endtask
   initial begin
      repeat (20000) @(posedge mclk);
      err_count++;
      wrap_up();
   end
   // ----------------------------------------
   // scenarios
   // ----------------------------------------
   initial begin
      reset = 1'b1;
      restart = 1'b0;
      wake_up_event = 1'b0;
      bus_timeout_event = 1'b0;
      bus_timeout_clear = 1'b0;
      mode = SWCR_MODE_NORMAL;
      void'($urandom(93659));
      do_reset();
      rdall();
      repeat (6) begin
         repeat (8) wrm('h20 + $urandom_range(6), 8'($urandom));
         rdall();
      end
      for (int k = 0; k < 4; k++) begin
         wrm('h20, {1'b1, k[1:0], 5'h10});
         wrm(`SWCR_ADDR_OPTION, 8'($urandom));
         repeat (4) @(negedge mclk);
         chk(cal_act, k == 3);
         chk(trim_ref, (k == 3) & tx_d2);
         chk(wake_option_register, opt[7:0]);
      end
      wrm('h20, 8'h60);
      repeat (4) @(negedge mclk);
      chk(cal_act, 0);
      for (int m = 0; m < 5; m++) begin
         wrm('h20, (m < 4) ? 8'h11 : 8'h01);
         mode = swcr_mode_e'(m[1:0]);
         repeat (2) @(negedge mclk);
         chk(selective_wake_enable, 1);
         pulse(bus_timeout_event);
         chk(bus_timeout_flag, 1);
         chk(interrupt_out_n, !(m < 2));
         pulse(bus_timeout_clear);
         chk(interrupt_out_n, 1);
      end
      pulse(wake_up_event);
      chk(selective_wake_enable, 0);
      pulse(bus_timeout_event);
      chk(bus_timeout_flag, 0);
      wrm('h20, 8'hf1);
      pulse(restart);
      mdl[0] = 'hf0;
      rdall();
      do_reset();
      rdall();
      wrap_up();
   end
endmodule
